// ---- verilog/pos_defs.vh ----
/*
  shared constants of the pwm output shutdown block: register byte offsets,
  field positions, reset values, detection mode codes and sampling counts.
  assumes inclusion by bare name from the design files and the bench of this block.
*/
`ifndef POS_DEFS_VH
`define POS_DEFS_VH

// register byte offsets, one aligned 32-bit word each
`define POS_OFS_IN_B 8'h00
`define POS_OFS_IN_C 8'h04
`define POS_OFS_SW_REQ 8'h08
`define POS_OFS_CH0_EN 8'h0c
`define POS_OFS_PAIR_EN 8'h10
`define POS_OFS_IN_ADE 8'h14
`define POS_OFS_OC 8'h18

// detection mode codes of a two-bit select field
`define POS_SEL_EDGE 2'h0
`define POS_SEL_DIV8 2'h1
`define POS_SEL_DIV16 2'h2
`define POS_SEL_DIV128 2'h3

// field positions
`define POS_F_SEL_LSB 0
`define POS_F_SEL_D_LSB 2
`define POS_F_SEL_E_LSB 4
`define POS_F_IRQ_EN 8
`define POS_F_C_FLOAT_EN 9
`define POS_F_FLAG 12
`define POS_F_FLAG_D 13
`define POS_F_FLAG_E 14
`define POS_F_OSC_FLAG 13

// software float request bits
`define POS_SW_CH34 0
`define POS_SW_CH67 1
`define POS_SW_CH0 2
`define POS_SW_PWM01 3
`define POS_SW_PWM23 4

// pair float enable bits
`define POS_PAIR_CH3_BD 0
`define POS_PAIR_CH4_AC 1
`define POS_PAIR_CH4_BD 2
`define POS_PAIR_CH6_BD 3
`define POS_PAIR_CH7_AC 4
`define POS_PAIR_CH7_BD 5

// reset values
`define POS_RST_SEL 2'h0
`define POS_RST_SW_REQ 5'h00
`define POS_RST_CH0_EN 4'h0
`define POS_RST_PAIR_EN 6'h00

// low-level sampling: consecutive low samples and clock dividers
`define POS_LOW_SAMPLES 16
`define POS_DIV_A 8
`define POS_DIV_B 16
`define POS_DIV_C 128

// axi response codes
`define POS_RESP_OKAY 2'h0
`define POS_RESP_SLVERR 2'h2

`endif

// ---- verilog/pos_detect.v ----
/*
  one fault input detector: falling edge or a run of consecutive low samples
  taken at one of three divided clock rates.
  assumes the pin level is already synchronised to the clock and the three
  sample ticks are one-cycle pulses from a shared prescaler.
*/
`timescale 1ns/100ps
`include "pos_defs.vh"

module pos_detect #(
  parameter SAMPLES = `POS_LOW_SAMPLES
) (
  input wire clk,
  input wire rst,
  input wire pin,
  input wire [1:0] sel,
  input wire tick_a,
  input wire tick_b,
  input wire tick_c,
  output wire hit
);

  reg pin_prev;
  reg [4:0] low_cnt;
  reg sample;

  // pick the sample tick for the selected rate
  always @* begin
    case (sel)
      `POS_SEL_DIV8: sample = tick_a;
      `POS_SEL_DIV16: sample = tick_b;
      `POS_SEL_DIV128: sample = tick_c;
      default: sample = 1'b0;
    endcase
  end

  // run counter saturates so the hit stays up while the pin stays low
  always @(posedge clk) begin
    if (rst) begin
      pin_prev <= 1'b1;
      low_cnt <= 5'h00;
    end else begin
      pin_prev <= pin;
      if (sel == `POS_SEL_EDGE)
        low_cnt <= 5'h00;
      else if (sample) begin
        if (pin)
          low_cnt <= 5'h00;
        else if (low_cnt != SAMPLES[4:0])
          low_cnt <= low_cnt + 5'h01;
      end
    end
  end

  assign hit = (sel == `POS_SEL_EDGE) ? (pin_prev & ~pin) : (low_cnt == SAMPLES[4:0]);

endmodule // pos_detect

// ---- verilog/pos_top.v ----
/*
  pwm output shutdown block with an axi4-lite register slave. five active-low
  fault pins, an oscillator stop input, complementary output comparison and
  software requests drive registered float outputs toward the timer pins.
  assumes one clock, synchronous active-high reset, fault pins asynchronous
  to the clock, and the stop and level inputs coming from logic on the clock.
*/
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pos_defs.vh"

module pos_top #(
  parameter NPAIR = 6
) (
  input wire MCLK,
  input wire RESET,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  input wire FAULT_IN_A_N,
  input wire FAULT_IN_B_N,
  input wire FAULT_IN_C_N,
  input wire FAULT_IN_D_N,
  input wire FAULT_IN_E_N,
  input wire OSC_STOP,
  input wire [NPAIR-1:0] PAIR_POS_ACTIVE,
  input wire [NPAIR-1:0] PAIR_NEG_ACTIVE,
  output reg [3:0] CH0_FLOAT,
  output reg [5:0] PAIR_FLOAT,
  output reg [3:0] PWM_FLOAT,
  output reg IRQ
);

  // set wins over a clear that lands in the same cycle
  function flag_next;
    input flag;
    input set;
    input clr;
    begin
      flag_next = set | (flag & ~clr);
    end
  endfunction

  // known offsets only; anything else answers with an error
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `POS_OFS_IN_B) | (a == `POS_OFS_IN_C) | (a == `POS_OFS_SW_REQ) |
               (a == `POS_OFS_CH0_EN) | (a == `POS_OFS_PAIR_EN) | (a == `POS_OFS_IN_ADE) |
               (a == `POS_OFS_OC);
    end
  endfunction

  reg [4:0] pin_meta;
  reg [4:0] pin_sync;
  reg [6:0] pre;
  reg [1:0] sel_a;
  reg [1:0] sel_b;
  reg [1:0] sel_c;
  reg [1:0] sel_d;
  reg [1:0] sel_e;
  reg flag_a;
  reg flag_b;
  reg flag_c;
  reg flag_d;
  reg flag_e;
  reg flag_osc;
  reg flag_oc;
  reg b_irq_en;
  reg group3_irq_en;
  reg ade_irq_en;
  reg oc_irq_en;
  reg in_c_float_en;
  reg [4:0] sw_req;
  reg [3:0] ch0_en;
  reg [5:0] pair_en;
  reg aw_full;
  reg w_full;
  reg [7:0] waddr;
  reg [31:0] wdata;
  reg [3:0] wstrb;
  reg [31:0] rd_word;
  wire [4:0] hit;
  wire [9:0] sel_all;
  wire tick_a;
  wire tick_b;
  wire tick_c;
  wire do_write;
  wire lane0;
  wire lane1;
  wire clr_a;
  wire clr_b;
  wire clr_c;
  wire clr_d;
  wire clr_e;
  wire clr_osc;
  wire clr_oc;
  wire both_active;
  wire grp_ch34;
  wire grp_ch67;
  wire grp_ch0;
  wire grp_pwm01;
  wire grp_pwm23;

  // two flops on every fault pin; only the second stage is read
  always @(posedge MCLK) begin
    if (RESET) begin
      pin_meta <= 5'h1f;
      pin_sync <= 5'h1f;
    end else begin
      pin_meta <= {FAULT_IN_E_N, FAULT_IN_D_N, FAULT_IN_C_N, FAULT_IN_B_N, FAULT_IN_A_N};
      pin_sync <= pin_meta;
    end
  end

  // shared prescaler keeps the three sample rates phase locked
  always @(posedge MCLK) begin
    if (RESET)
      pre <= 7'h00;
    else
      pre <= pre + 7'h01;
  end

  assign tick_a = (pre[2:0] == (`POS_DIV_A - 1));
  assign tick_b = (pre[3:0] == (`POS_DIV_B - 1));
  assign tick_c = (pre == (`POS_DIV_C - 1));
  assign sel_all = {sel_e, sel_d, sel_c, sel_b, sel_a};

  // one detector per fault pin
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_det
      pos_detect #(
        .SAMPLES(`POS_LOW_SAMPLES)
      ) u_det (
        .clk(MCLK),
        .rst(RESET),
        .pin(pin_sync[gi]),
        .sel(sel_all[2*gi+1:2*gi]),
        .tick_a(tick_a),
        .tick_b(tick_b),
        .tick_c(tick_c),
        .hit(hit[gi])
      );
    end
  endgenerate

  // write address channel, held until the response is taken
  always @(posedge MCLK) begin
    if (RESET) begin
      AWREADY <= 1'b0;
      aw_full <= 1'b0;
      waddr <= 8'h00;
    end else if (AWVALID & AWREADY) begin
      AWREADY <= 1'b0;
      aw_full <= 1'b1;
      waddr <= {AWADDR[7:2], 2'b00};
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (~aw_full & ~BVALID) begin
      AWREADY <= 1'b1;
    end
  end

  // write data channel, taken independently of the address
  always @(posedge MCLK) begin
    if (RESET) begin
      WREADY <= 1'b0;
      w_full <= 1'b0;
      wdata <= 32'h00000000;
      wstrb <= 4'h0;
    end else if (WVALID & WREADY) begin
      WREADY <= 1'b0;
      w_full <= 1'b1;
      wdata <= WDATA;
      wstrb <= WSTRB;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (~w_full & ~BVALID) begin
      WREADY <= 1'b1;
    end
  end

  assign do_write = aw_full & w_full & ~BVALID;

  // response one cycle after both halves are held
  always @(posedge MCLK) begin
    if (RESET) begin
      BVALID <= 1'b0;
      BRESP <= `POS_RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      BRESP <= mapped(waddr) ? `POS_RESP_OKAY : `POS_RESP_SLVERR;
    end else if (BVALID & BREADY) begin
      BVALID <= 1'b0;
    end
  end

  assign lane0 = do_write & wstrb[0];
  assign lane1 = do_write & wstrb[1];

  // flags clear on a written zero in their lane, keep on a written one
  assign clr_b = lane1 & (waddr == `POS_OFS_IN_B) & ~wdata[`POS_F_FLAG];
  assign clr_c = lane1 & (waddr == `POS_OFS_IN_C) & ~wdata[`POS_F_FLAG];
  assign clr_a = lane1 & (waddr == `POS_OFS_IN_ADE) & ~wdata[`POS_F_FLAG];
  assign clr_d = lane1 & (waddr == `POS_OFS_IN_ADE) & ~wdata[`POS_F_FLAG_D];
  assign clr_e = lane1 & (waddr == `POS_OFS_IN_ADE) & ~wdata[`POS_F_FLAG_E];
  assign clr_oc = lane1 & (waddr == `POS_OFS_OC) & ~wdata[`POS_F_FLAG];
  assign clr_osc = lane1 & (waddr == `POS_OFS_OC) & ~wdata[`POS_F_OSC_FLAG];

  assign both_active = |(PAIR_POS_ACTIVE & PAIR_NEG_ACTIVE);

  // control fields written by software
  always @(posedge MCLK) begin
    if (RESET) begin
      sel_a <= `POS_RST_SEL;
      sel_b <= `POS_RST_SEL;
      sel_c <= `POS_RST_SEL;
      sel_d <= `POS_RST_SEL;
      sel_e <= `POS_RST_SEL;
      b_irq_en <= 1'b0;
      group3_irq_en <= 1'b0;
      ade_irq_en <= 1'b0;
      oc_irq_en <= 1'b0;
      in_c_float_en <= 1'b0;
      sw_req <= `POS_RST_SW_REQ;
      ch0_en <= `POS_RST_CH0_EN;
      pair_en <= `POS_RST_PAIR_EN;
    end else begin
      if (lane0 & (waddr == `POS_OFS_IN_B))
        sel_b <= wdata[`POS_F_SEL_LSB+1:`POS_F_SEL_LSB];
      if (lane0 & (waddr == `POS_OFS_IN_C))
        sel_c <= wdata[`POS_F_SEL_LSB+1:`POS_F_SEL_LSB];
      if (lane0 & (waddr == `POS_OFS_IN_ADE)) begin
        sel_a <= wdata[`POS_F_SEL_LSB+1:`POS_F_SEL_LSB];
        sel_d <= wdata[`POS_F_SEL_D_LSB+1:`POS_F_SEL_D_LSB];
        sel_e <= wdata[`POS_F_SEL_E_LSB+1:`POS_F_SEL_E_LSB];
      end
      if (lane1 & (waddr == `POS_OFS_IN_B))
        b_irq_en <= wdata[`POS_F_IRQ_EN];
      if (lane1 & (waddr == `POS_OFS_IN_C)) begin
        group3_irq_en <= wdata[`POS_F_IRQ_EN];
        in_c_float_en <= wdata[`POS_F_C_FLOAT_EN];
      end
      if (lane1 & (waddr == `POS_OFS_IN_ADE))
        ade_irq_en <= wdata[`POS_F_IRQ_EN];
      if (lane1 & (waddr == `POS_OFS_OC))
        oc_irq_en <= wdata[`POS_F_IRQ_EN];
      if (lane0 & (waddr == `POS_OFS_SW_REQ))
        sw_req <= wdata[4:0];
      if (lane0 & (waddr == `POS_OFS_CH0_EN))
        ch0_en <= wdata[3:0];
      if (lane0 & (waddr == `POS_OFS_PAIR_EN))
        pair_en <= wdata[5:0];
    end
  end

  // sticky cause flags; a still-present cause sets again over the clear
  always @(posedge MCLK) begin
    if (RESET) begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      flag_c <= 1'b0;
      flag_d <= 1'b0;
      flag_e <= 1'b0;
      flag_osc <= 1'b0;
      flag_oc <= 1'b0;
    end else begin
      flag_a <= flag_next(flag_a, hit[0], clr_a);
      flag_b <= flag_next(flag_b, hit[1], clr_b);
      flag_c <= flag_next(flag_c, hit[2], clr_c);
      flag_d <= flag_next(flag_d, hit[3], clr_d);
      flag_e <= flag_next(flag_e, hit[4], clr_e);
      flag_osc <= flag_next(flag_osc, OSC_STOP, clr_osc);
      flag_oc <= flag_next(flag_oc, both_active, clr_oc);
    end
  end

  assign grp_ch34 = sw_req[`POS_SW_CH34] | flag_a | flag_b | flag_osc | flag_oc;
  assign grp_ch67 = sw_req[`POS_SW_CH67] | flag_a | flag_osc;
  assign grp_ch0 = sw_req[`POS_SW_CH0] | (flag_c & in_c_float_en) | flag_osc;
  assign grp_pwm01 = sw_req[`POS_SW_PWM01] | flag_d | flag_osc;
  assign grp_pwm23 = sw_req[`POS_SW_PWM23] | flag_e | flag_osc;

  // float outputs are registered so the pins never see decode glitches
  always @(posedge MCLK) begin
    if (RESET) begin
      CH0_FLOAT <= 4'h0;
      PAIR_FLOAT <= 6'h00;
      PWM_FLOAT <= 4'h0;
    end else begin
      CH0_FLOAT <= ch0_en & {4{grp_ch0}};
      PAIR_FLOAT[`POS_PAIR_CH3_BD] <= pair_en[`POS_PAIR_CH3_BD] & grp_ch34;
      PAIR_FLOAT[`POS_PAIR_CH4_AC] <= pair_en[`POS_PAIR_CH4_AC] & grp_ch34;
      PAIR_FLOAT[`POS_PAIR_CH4_BD] <= pair_en[`POS_PAIR_CH4_BD] & grp_ch34;
      PAIR_FLOAT[`POS_PAIR_CH6_BD] <= pair_en[`POS_PAIR_CH6_BD] & grp_ch67;
      PAIR_FLOAT[`POS_PAIR_CH7_AC] <= pair_en[`POS_PAIR_CH7_AC] & grp_ch67;
      PAIR_FLOAT[`POS_PAIR_CH7_BD] <= pair_en[`POS_PAIR_CH7_BD] & grp_ch67;
      // pwm 0 to 2 follow the channel 3/4 software bit and comparison too
      PWM_FLOAT[0] <= grp_pwm01 | sw_req[`POS_SW_CH34] | flag_oc;
      PWM_FLOAT[1] <= grp_pwm01 | sw_req[`POS_SW_CH34] | flag_oc;
      PWM_FLOAT[2] <= grp_pwm23 | sw_req[`POS_SW_CH34] | flag_oc;
      PWM_FLOAT[3] <= grp_pwm23;
    end
  end

  always @(posedge MCLK) begin
    if (RESET)
      IRQ <= 1'b0;
    else
      IRQ <= (flag_c & group3_irq_en) | (flag_b & b_irq_en) |
             ((flag_a | flag_d | flag_e) & ade_irq_en) | (flag_oc & oc_irq_en);
  end

  // read word assembly; unused bits read zero
  always @* begin
    rd_word = 32'h00000000;
    case ({ARADDR[7:2], 2'b00})
      `POS_OFS_IN_B: begin
        rd_word[`POS_F_SEL_LSB+1:`POS_F_SEL_LSB] = sel_b;
        rd_word[`POS_F_IRQ_EN] = b_irq_en;
        rd_word[`POS_F_FLAG] = flag_b;
      end
      `POS_OFS_IN_C: begin
        rd_word[`POS_F_SEL_LSB+1:`POS_F_SEL_LSB] = sel_c;
        rd_word[`POS_F_IRQ_EN] = group3_irq_en;
        rd_word[`POS_F_C_FLOAT_EN] = in_c_float_en;
        rd_word[`POS_F_FLAG] = flag_c;
      end
      `POS_OFS_SW_REQ: rd_word[4:0] = sw_req;
      `POS_OFS_CH0_EN: rd_word[3:0] = ch0_en;
      `POS_OFS_PAIR_EN: rd_word[5:0] = pair_en;
      `POS_OFS_IN_ADE: begin
        rd_word[`POS_F_SEL_LSB+1:`POS_F_SEL_LSB] = sel_a;
        rd_word[`POS_F_SEL_D_LSB+1:`POS_F_SEL_D_LSB] = sel_d;
        rd_word[`POS_F_SEL_E_LSB+1:`POS_F_SEL_E_LSB] = sel_e;
        rd_word[`POS_F_IRQ_EN] = ade_irq_en;
        rd_word[`POS_F_FLAG] = flag_a;
        rd_word[`POS_F_FLAG_D] = flag_d;
        rd_word[`POS_F_FLAG_E] = flag_e;
      end
      `POS_OFS_OC: begin
        rd_word[`POS_F_IRQ_EN] = oc_irq_en;
        rd_word[`POS_F_FLAG] = flag_oc;
        rd_word[`POS_F_OSC_FLAG] = flag_osc;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // read channel: data registered at the address handshake
  always @(posedge MCLK) begin
    if (RESET) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `POS_RESP_OKAY;
    end else if (ARVALID & ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= mapped({ARADDR[7:2], 2'b00}) ? `POS_RESP_OKAY : `POS_RESP_SLVERR;
    end else if (RVALID & RREADY) begin
      RVALID <= 1'b0;
    end else if (~RVALID) begin
      ARREADY <= 1'b1;
    end
  end

endmodule // pos_top

// ---- sim/pos_props.sv ----
/*
  checker on the pos_top ports: bus answers, float causes and pin gating.
  assumes it is bound to pos_top and that writes offer address and data together.
*/
`timescale 1ns/100ps
module pos_props #(
  parameter NPAIR = 6
) (
  input wire MCLK,
  input wire RESET,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  input wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  input wire WREADY,
  input wire [1:0] BRESP,
  input wire BVALID,
  input wire BREADY,
  input wire [31:0] RDATA,
  input wire RVALID,
  input wire RREADY,
  input wire FAULT_IN_E_N,
  input wire OSC_STOP,
  input wire [NPAIR-1:0] PAIR_POS_ACTIVE,
  input wire [NPAIR-1:0] PAIR_NEG_ACTIVE,
  input wire [3:0] CH0_FLOAT,
  input wire [5:0] PAIR_FLOAT,
  input wire [3:0] PWM_FLOAT
);
  reg [1:0] e_mode;
  reg [3:0] ch0_en;
  reg [5:0] pair_en;
  wire wr_now = AWVALID && AWREADY && WVALID && WREADY && WSTRB[0];

  // shadow of written enables; only writes taken in one cycle are seen
  always @(posedge MCLK) begin
    if (RESET) begin
      e_mode <= 2'h0;
      ch0_en <= 4'h0;
      pair_en <= 6'h00;
    end else if (wr_now) begin
      if (AWADDR[7:2] == 6'h05) e_mode <= WDATA[5:4];
      if (AWADDR[7:2] == 6'h03) ch0_en <= WDATA[3:0];
      if (AWADDR[7:2] == 6'h04) pair_en <= WDATA[5:0];
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_b_answer;
    ##[1:2] BVALID;
  endsequence
  sequence s_e_fall;
    e_mode == 2'h0 && $fell(FAULT_IN_E_N);
  endsequence
  property p_wr_answer;
    s_wr_taken |-> s_b_answer;
  endproperty
  property p_b_hold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  property p_osc;
    OSC_STOP |-> ##[1:3] (PWM_FLOAT == 4'hf);
  endproperty
  property p_oc;
    (PAIR_POS_ACTIVE & PAIR_NEG_ACTIVE) != 0 |-> ##[1:3] (PWM_FLOAT[2:0] == 3'h7);
  endproperty
  property p_e_edge;
    s_e_fall |-> ##[2:6] PWM_FLOAT[3];
  endproperty
  property p_osc_hold;
    $fell(PWM_FLOAT[3]) |-> !$past(OSC_STOP);
  endproperty
  // pin enables may lag the write by the register and output stages
  property p_ch0_gate;
    (CH0_FLOAT & ~(ch0_en | $past(ch0_en) | $past(ch0_en, 2) | $past(ch0_en, 3))) == 4'h0;
  endproperty
  property p_pair_gate;
    (PAIR_FLOAT & ~(pair_en | $past(pair_en) | $past(pair_en, 2) | $past(pair_en, 3))) == 6'h00;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write taken without response");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  a_osc: assert property (p_osc) else $error("oscillator stop did not float");
  a_oc: assert property (p_oc) else $error("overlap did not float");
  a_e_edge: assert property (p_e_edge) else $error("falling edge did not float");
  a_osc_hold: assert property (p_osc_hold) else $error("float released during stop");
  a_ch0_gate: assert property (p_ch0_gate) else $error("disabled channel 0 pin floated");
  a_pair_gate: assert property (p_pair_gate) else $error("disabled pair floated");
endmodule // pos_props

bind pos_top pos_props #(.NPAIR(NPAIR)) u_pos_props (
  .MCLK(MCLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
  .FAULT_IN_E_N(FAULT_IN_E_N), .OSC_STOP(OSC_STOP), .PAIR_POS_ACTIVE(PAIR_POS_ACTIVE),
  .PAIR_NEG_ACTIVE(PAIR_NEG_ACTIVE), .CH0_FLOAT(CH0_FLOAT), .PAIR_FLOAT(PAIR_FLOAT),
  .PWM_FLOAT(PWM_FLOAT)
);

// ---- sim/pos_far.sv ----
/*
  far-side model: pulled-up fault pins, the clock monitor stop level and the
  complementary output levels of the timers.
  assumes the bench moves the request inputs right after a rising edge.
*/
`timescale 1ns/100ps
module pos_far (
  input wire MCLK,
  input wire [4:0] low_req,
  input wire stop_req,
  input wire [5:0] pos_req,
  input wire [5:0] neg_req,
  input wire [5:0] pair_float,
  output reg [4:0] fault_n,
  output reg osc_stop,
  output reg [5:0] pos_active,
  output reg [5:0] neg_active
);
  // idle levels from time zero: pins pulled up, clock running, outputs off
  initial begin
    fault_n = 5'h1f;
    osc_stop = 1'b0;
    pos_active = 6'h00;
    neg_active = 6'h00;
  end
  // pin level held
  // pins move half a cycle off the sampling edge, as an outside source would
  always @(negedge MCLK) begin
    fault_n <= ~low_req;
  end
  // stop and overlap
  // a floated pair loses its levels, so an overlap ends once it is acted on
  always @(posedge MCLK) begin
    osc_stop <= stop_req;
    pos_active <= pos_req & ~pair_float;
    neg_active <= neg_req & ~pair_float;
  end
endmodule // pos_far

// ---- sim/tb_top.sv ----
/*
  bench for pos_top: register calls over axi4-lite and pin stimulus through pos_far.
  assumes pos_top, pos_far and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`include "pos_defs.vh"
module tb_top;
  logic MCLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY, stop_req;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA;
  logic [3:0] WSTRB;
  logic [4:0] low_req;
  logic [5:0] pos_req, neg_req;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, OSC_STOP;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [4:0] fault_n;
  wire [5:0] PAIR_POS_ACTIVE, PAIR_NEG_ACTIVE, PAIR_FLOAT;
  wire [3:0] CH0_FLOAT, PWM_FLOAT;
  int miscompares, total_checks, i, m, d;
  // software request rows: request, pin enables, expected floats
  logic [4:0] t_sw [0:5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h05};
  logic [3:0] t_cen [0:5] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h5};
  logic [5:0] t_pen [0:5] = '{6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h0a};
  logic [3:0] t_c0 [0:5] = '{4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'h5};
  logic [5:0] t_pr [0:5] = '{6'h07, 6'h38, 6'h00, 6'h00, 6'h00, 6'h02};
  logic [3:0] t_pw [0:5] = '{4'h7, 4'h0, 4'h0, 4'h3, 4'hc, 4'h7};

  pos_top u_pos_top (
    .MCLK(MCLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .FAULT_IN_A_N(fault_n[0]), .FAULT_IN_B_N(fault_n[1]), .FAULT_IN_C_N(fault_n[2]),
    .FAULT_IN_D_N(fault_n[3]), .FAULT_IN_E_N(fault_n[4]), .OSC_STOP(OSC_STOP),
    .PAIR_POS_ACTIVE(PAIR_POS_ACTIVE), .PAIR_NEG_ACTIVE(PAIR_NEG_ACTIVE),
    .CH0_FLOAT(CH0_FLOAT), .PAIR_FLOAT(PAIR_FLOAT), .PWM_FLOAT(PWM_FLOAT), .IRQ(IRQ)
  );
  pos_far u_pos_far (
    .MCLK(MCLK), .low_req(low_req), .stop_req(stop_req), .pos_req(pos_req), .neg_req(neg_req),
    .pair_float(PAIR_FLOAT), .fault_n(fault_n), .osc_stop(OSC_STOP),
    .pos_active(PAIR_POS_ACTIVE), .neg_active(PAIR_NEG_ACTIVE)
  );

  // free-running 100 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic waitc(input int k);
    repeat (k) @(posedge MCLK);
  endtask

  // response ready stands from the request on, so the answer is taken when first seen
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    int n;
    AWADDR <= a;
    WDATA <= dat;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge MCLK);
      if (BVALID && BREADY) break;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end
    if (n == 200) begin
      miscompares++;
      close_out();
    end
    chk("write response", {30'h0, er}, {30'h0, BRESP});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge MCLK);
      if (RVALID && RREADY) break;
      if (ARREADY) ARVALID <= 1'b0;
    end
    if (n == 200) begin
      miscompares++;
      close_out();
    end
    chk("read data", ex, RDATA);
    chk("read response", {30'h0, er}, {30'h0, RRESP});
  endtask

  // outputs are registered, so give them three edges to settle
  task automatic outs(input logic [3:0] c, input logic [5:0] p, input logic [3:0] w, input logic q);
    repeat (3) @(posedge MCLK);
    chk("channel 0 float", {28'h0, c}, {28'h0, CH0_FLOAT});
    chk("pair float", {26'h0, p}, {26'h0, PAIR_FLOAT});
    chk("pwm float", {28'h0, w}, {28'h0, PWM_FLOAT});
    chk("interrupt", {31'h0, q}, {31'h0, IRQ});
  endtask

  // main sequence
  initial begin
    RESET = 1'b1;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hf;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, stop_req} = 6'h00;
    {low_req, pos_req, neg_req} = 17'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (16) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    for (i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, (i == 7) ? `POS_RESP_SLVERR : `POS_RESP_OKAY);
    wr(8'h1c, 32'hffff_ffff, `POS_RESP_SLVERR);
    $display("test reset map done");
    for (i = 0; i < 6; i++) begin
      wr(`POS_OFS_CH0_EN, {28'h0, t_cen[i]}, `POS_RESP_OKAY);
      wr(`POS_OFS_PAIR_EN, {26'h0, t_pen[i]}, `POS_RESP_OKAY);
      wr(`POS_OFS_SW_REQ, {27'h0, t_sw[i]}, `POS_RESP_OKAY);
      outs(t_c0[i], t_pr[i], t_pw[i], 1'b0);
      rd(`POS_OFS_SW_REQ, {27'h0, t_sw[i]}, `POS_RESP_OKAY);
    end
    wr(`POS_OFS_SW_REQ, 32'h0, `POS_RESP_OKAY);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    wr(`POS_OFS_CH0_EN, 32'hf, `POS_RESP_OKAY);
    wr(`POS_OFS_PAIR_EN, 32'h3f, `POS_RESP_OKAY);
    $display("test software float done");
    low_req <= 5'h10;
    waitc(8);
    outs(4'h0, 6'h00, 4'hc, 1'b0);
    rd(`POS_OFS_IN_ADE, 32'h4000, `POS_RESP_OKAY);
    low_req <= 5'h00;
    waitc(8);
    outs(4'h0, 6'h00, 4'hc, 1'b0);
    wr(`POS_OFS_IN_ADE, 32'h0, `POS_RESP_OKAY);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    $display("test edge done");
    for (m = 1; m < 4; m++) begin
      d = (m == 1) ? `POS_DIV_A : (m == 2) ? `POS_DIV_B : `POS_DIV_C;
      wr(`POS_OFS_IN_B, 32'h100 + 32'(m), `POS_RESP_OKAY);
      low_req <= 5'h02;
      waitc((`POS_LOW_SAMPLES - 1) * d - 1);
      low_req <= 5'h00;
      waitc(6);
      outs(4'h0, 6'h00, 4'h0, 1'b0);
      low_req <= 5'h02;
      waitc(`POS_LOW_SAMPLES * d + 8);
      outs(4'h0, 6'h07, 4'h0, 1'b1);
      rd(`POS_OFS_IN_B, 32'h1100 + 32'(m), `POS_RESP_OKAY);
      low_req <= 5'h00;
      // the run stays counted until a sample tick sees the pin high again
      waitc(d + 4);
      wr(`POS_OFS_IN_B, 32'h100 + 32'(m), `POS_RESP_OKAY);
      outs(4'h0, 6'h00, 4'h0, 1'b0);
    end
    $display("test level done");
    low_req <= 5'h04;
    waitc(8);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    rd(`POS_OFS_IN_C, 32'h1000, `POS_RESP_OKAY);
    low_req <= 5'h00;
    waitc(4);
    wr(`POS_OFS_IN_C, 32'h300, `POS_RESP_OKAY);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    low_req <= 5'h04;
    waitc(8);
    outs(4'hf, 6'h00, 4'h0, 1'b1);
    low_req <= 5'h00;
    waitc(4);
    wr(`POS_OFS_IN_C, 32'h0, `POS_RESP_OKAY);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    $display("test group enables done");
    stop_req <= 1'b1;
    waitc(4);
    outs(4'hf, 6'h3f, 4'hf, 1'b0);
    rd(`POS_OFS_OC, 32'h2000, `POS_RESP_OKAY);
    wr(`POS_OFS_OC, 32'h0, `POS_RESP_OKAY);
    outs(4'hf, 6'h3f, 4'hf, 1'b0);
    stop_req <= 1'b0;
    waitc(2);
    wr(`POS_OFS_OC, 32'h0, `POS_RESP_OKAY);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    $display("test oscillator stop done");
    wr(`POS_OFS_OC, 32'h100, `POS_RESP_OKAY);
    pos_req <= 6'h3f;
    waitc(4);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    neg_req <= 6'h01;
    waitc(4);
    outs(4'h0, 6'h07, 4'h7, 1'b1);
    rd(`POS_OFS_OC, 32'h1100, `POS_RESP_OKAY);
    pos_req <= 6'h00;
    neg_req <= 6'h00;
    waitc(2);
    wr(`POS_OFS_OC, 32'h100, `POS_RESP_OKAY);
    outs(4'h0, 6'h00, 4'h0, 1'b0);
    $display("test overlap done");
    close_out();
  end
endmodule // tb_top
